// ==== logic/smsp_pkg.sv ====
// Shared constants, register layout and state types for the serial peripheral port.
package smsp_pkg;

	// Register indices; the Wishbone byte address is four times the index.
	localparam logic [9:0] SMSP_IDX_CTRL = 10'h0d2;
	localparam logic [9:0] SMSP_IDX_DATA = 10'h0d3;
	localparam logic [9:0] SMSP_IDX_STAT = 10'h0d4;
	localparam logic [9:0] SMSP_IDX_AUX  = 10'h0d5;

	// Control register fields.
	localparam int SMSP_CTRL_EN   = 7;
	localparam int SMSP_CTRL_LSBF = 6;
	localparam int SMSP_CTRL_MS   = 5;
	localparam int SMSP_CTRL_CLOCK_IDLE_LEVEL_BIT = 4;
	localparam int SMSP_CTRL_CLOCK_EDGE_PHASE_BIT = 3;
	localparam int SMSP_CTRL_DOUBLE_RATE_BIT = 2;
	localparam int SMSP_CTRL_CLOCK_RATE_BIT_HI = 1;
	localparam int SMSP_CTRL_CLOCK_RATE_BIT_LO = 0;

	// Status register fields.
	localparam int SMSP_STAT_TC     = 7;
	localparam int SMSP_STAT_WCOL   = 6;
	localparam int SMSP_STAT_SSHIGH = 5;
	localparam int SMSP_STAT_TWOPIN = 3;
	localparam int SMSP_STAT_SELECT_ENABLE_BIT  = 2;
	localparam int SMSP_STAT_TRANSMIT_ENABLE_BIT  = 1;
	localparam int SMSP_STAT_RECEIVE_ENABLE_BIT  = 0;

	// Auxiliary register fields: select pin data, select pin direction, interrupt enable.
	localparam int SMSP_AUX_SSOUT = 0;
	localparam int SMSP_AUX_SSDIR = 1;
	localparam int SMSP_AUX_IE    = 2;

	// Reset values of the software-visible registers.
	localparam logic [7:0] SMSP_CTRL_RST = 8'h00;
	localparam logic [7:0] SMSP_DATA_RST = 8'h00;
	localparam logic [7:0] SMSP_STAT_RST = 8'h00;
	localparam logic [7:0] SMSP_AUX_RST  = 8'h00;

	// Serial clock half periods in system clocks, indexed by double-rate and rate bits.
	localparam logic [6:0] SMSP_HALF_DIV4   = 7'h02;
	localparam logic [6:0] SMSP_HALF_DIV16  = 7'h08;
	localparam logic [6:0] SMSP_HALF_DIV64  = 7'h20;
	localparam logic [6:0] SMSP_HALF_DIV128 = 7'h40;
	localparam logic [6:0] SMSP_HALF_DIV2   = 7'h01;
	localparam logic [6:0] SMSP_HALF_DIV8   = 7'h04;
	localparam logic [6:0] SMSP_HALF_DIV32  = 7'h10;

	// Index of the last of the eight bits and of the last of the sixteen edges of a transfer.
	localparam logic [2:0] SMSP_LAST_BIT  = 3'h7;
	localparam logic [3:0] SMSP_LAST_EDGE = 4'hf;

	// Transfer engine states.
	typedef enum logic [1:0] {
		SMSP_IDLE  = 2'h0,
		SMSP_SHIFT = 2'h1
	} smsp_fsm_t;

	// Pin drive group.
	typedef struct packed {
		logic sck_o;
		logic sck_oe;
		logic mosi_o;
		logic mosi_oe;
		logic miso_o;
		logic miso_oe;
		logic ss_o;
		logic ss_oe;
	} smsp_pins_t;

	// Complete state of the port.
	typedef struct packed {
		smsp_fsm_t   fsm;
		logic [7:0]  ctrl;
		logic        tc;
		logic        wcol;
		logic        ss_high;
		logic        twopin;
		logic        select_enable_bit;
		logic        transmit_enable_bit;
		logic        receive_enable_bit;
		logic        ss_out;
		logic        ss_dir;
		logic        irq_en;
		logic [7:0]  tx;
		logic [7:0]  sh;
		logic [7:0]  rx;
		logic        out_bit;
		logic        sck;
		logic [6:0]  div_cnt;
		logic [3:0]  edge_cnt;
		logic [2:0]  bit_cnt;
		logic        ss_prev;
		logic        sck_prev;
		logic        rd_armed;
		logic        ack;
		logic [31:0] dat;
		logic        irq;
		smsp_pins_t  pins;
	} smsp_state_t;

	localparam smsp_state_t SMSP_STATE_RST = '0;

	// Half period of the master serial clock for a rate selection.
	function automatic logic [6:0] smsp_half(input logic [2:0] sel);
		logic [6:0] h;
		h = SMSP_HALF_DIV4;
		case (sel)
			3'h0: h = SMSP_HALF_DIV4;
			3'h1: h = SMSP_HALF_DIV16;
			3'h2: h = SMSP_HALF_DIV64;
			3'h3: h = SMSP_HALF_DIV128;
			3'h4: h = SMSP_HALF_DIV2;
			3'h5: h = SMSP_HALF_DIV8;
			3'h6: h = SMSP_HALF_DIV32;
			default: h = SMSP_HALF_DIV64;
		endcase
		return h;
	endfunction : smsp_half

endpackage : smsp_pkg

// ==== logic/smsp_sync.sv ====
// Two flip-flop synchroniser bank for the asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module smsp_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys, // System clock.
	input  wire logic         rst_n,   // Synchronous reset, active low.
	input  wire logic [W-1:0] d,       // Asynchronous inputs.
	output logic      [W-1:0] q        // Synchronised outputs.
);

	logic [W-1:0] meta_r;

	// The first stage feeds only the second, so metastability never reaches logic.
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk_sys) begin
				if (!rst_n) begin
					meta_r[i] <= 1'b0;
					q[i]      <= 1'b0;
				end else begin
					meta_r[i] <= d[i];
					q[i]      <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule : smsp_sync
`default_nettype wire

// ==== logic/smsp_top.sv ====
// Serial peripheral port with master and slave roles behind a Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Control register sets role, clock polarity and phase before a transfer.
// - Master selects its remote slave with an active-low select line.
// - Writing a byte into the data register starts a transfer.
// - Master drives the clock and exchanges eight bits on its data lines.
// - Slave takes the external clock and exchanges eight bits with the master.
// - Completion sets the done flag and requests an interrupt if enabled.
// - With interrupt enabled, servicing the interrupt clears the done flag.
// - Without interrupt, status read then data access clears the done flag.
// - Transmit enable off releases its data pin; with receive enable off, zeros are shifted in.
// - In slave role select is an input and logic runs only while low.
// - Slave with select high stops, resets shifting, drops partial data.
// - Master seeing select low becomes slave and sets the done flag.
// - Master with select as output drives software's port data bit.
// - Select disabled frees the pin; internal select high as master, low as slave.
// - Rising select input sets the select-high flag; writing zero clears it.
// - Bit-order bit: zero sends most significant first, one least first.
// - Polarity sets clock idle level; phase picks leading or trailing sample.
module smsp_top
	import smsp_pkg::*;
(
	input  wire logic        clk_sys,  // System clock, 25 MHz.
	input  wire logic        rst_n,    // Synchronous reset, active low.
	input  wire logic        wb_cyc_i, // Wishbone cycle.
	input  wire logic        wb_stb_i, // Wishbone strobe.
	input  wire logic        wb_we_i,  // Wishbone write enable.
	input  wire logic [11:0] wb_adr_i, // Wishbone byte address.
	input  wire logic [3:0]  wb_sel_i, // Wishbone byte selects.
	input  wire logic [31:0] wb_dat_i, // Wishbone write data.
	output logic      [31:0] wb_dat_o, // Wishbone read data.
	output logic             wb_ack_o, // Wishbone acknowledge.
	input  wire logic        int_ack,  // Interrupt serviced, one-cycle pulse.
	output logic             irq,      // Interrupt request, level.
	input  wire logic        sck_i,    // Serial clock pin level.
	output logic             sck_o,    // Serial clock drive value.
	output logic             sck_oe,   // Serial clock drive enable.
	input  wire logic        mosi_i,   // Master-out pin level.
	output logic             mosi_o,   // Master-out drive value.
	output logic             mosi_oe,  // Master-out drive enable.
	input  wire logic        miso_i,   // Master-in pin level.
	output logic             miso_o,   // Master-in drive value.
	output logic             miso_oe,  // Master-in drive enable.
	input  wire logic        ss_n_i,   // Select pin level, active low.
	output logic             ss_n_o,   // Select drive value, active low.
	output logic             ss_n_oe   // Select drive enable.
);

	smsp_state_t st_r;
	smsp_state_t st_nxt;
	logic [3:0]  pin_s;
	logic        sck_s;
	logic        mosi_s;
	logic        miso_s;
	logic        ss_s;

	// Every pin input is resynchronised before the engine looks at it.
	smsp_sync #(
		.W (4)
	) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({sck_i, mosi_i, miso_i, ss_n_i}),
		.q       (pin_s)
	);

	assign sck_s  = pin_s[3];
	assign mosi_s = pin_s[2];
	assign miso_s = pin_s[1];
	assign ss_s   = pin_s[0];

	// Next-state logic for the bus slave, flags and transfer engine.
	always_comb begin
		logic       en;
		logic       mst;
		logic       clock_idle_level_bit;
		logic       clock_edge_phase_bit;
		logic       lsbf;
		logic       ss_input;
		logic       ss_int;
		logic       din;
		logic       edge_ev;
		logic       lead;
		logic       trail;
		logic       sample;
		logic       setup;
		logic [6:0] half;
		logic [7:0] sh_in;
		logic       access;
		logic [9:0] idx;
		logic       data_acc;
		logic       col_ev;
		st_nxt   = st_r;
		en       = st_r.ctrl[SMSP_CTRL_EN];
		mst      = st_r.ctrl[SMSP_CTRL_MS];
		clock_idle_level_bit     = st_r.ctrl[SMSP_CTRL_CLOCK_IDLE_LEVEL_BIT];
		clock_edge_phase_bit     = st_r.ctrl[SMSP_CTRL_CLOCK_EDGE_PHASE_BIT];
		lsbf     = st_r.ctrl[SMSP_CTRL_LSBF];
		half     = smsp_half(st_r.ctrl[SMSP_CTRL_DOUBLE_RATE_BIT:SMSP_CTRL_CLOCK_RATE_BIT_LO]);
		edge_ev  = 1'b0;
		lead     = 1'b0;
		trail    = 1'b0;
		access   = wb_cyc_i && wb_stb_i && !st_r.ack;
		idx      = wb_adr_i[11:2];
		data_acc = 1'b0;
		col_ev   = 1'b0;
		sample   = 1'b0;
		setup    = 1'b0;
		// With select enabled a slave listens on the pin; a master only when its direction is also input.
		ss_input = st_r.select_enable_bit && !(mst && st_r.ss_dir);
		ss_int   = ss_input ? ss_s : mst;
		din      = st_r.receive_enable_bit && (mst ? miso_s : mosi_s);
		sh_in    = lsbf ? {din, st_r.sh[7:1]} : {st_r.sh[6:0], din};

		// Bus slave: one wait state, unmapped reads return zero and writes are dropped.
		st_nxt.ack = access;
		if (access && wb_we_i && wb_sel_i[0]) begin
			case (idx)
				SMSP_IDX_CTRL: st_nxt.ctrl = wb_dat_i[7:0];
				SMSP_IDX_DATA: begin
					data_acc = 1'b1;
					if (st_r.fsm == SMSP_SHIFT) begin
						col_ev = 1'b1;
					end else if (en) begin
						st_nxt.fsm      = SMSP_SHIFT;
						st_nxt.tx       = wb_dat_i[7:0];
						st_nxt.sh       = wb_dat_i[7:0];
						st_nxt.out_bit  = lsbf ? wb_dat_i[0] : wb_dat_i[7];
						st_nxt.div_cnt  = 7'h00;
						st_nxt.edge_cnt = 4'h0;
						st_nxt.bit_cnt  = 3'h0;
						st_nxt.sck      = clock_idle_level_bit;
					end
				end
				SMSP_IDX_STAT: begin
					if (!wb_dat_i[SMSP_STAT_SSHIGH]) begin
						st_nxt.ss_high = 1'b0;
					end
					st_nxt.twopin = wb_dat_i[SMSP_STAT_TWOPIN];
					st_nxt.select_enable_bit  = wb_dat_i[SMSP_STAT_SELECT_ENABLE_BIT];
					st_nxt.transmit_enable_bit  = wb_dat_i[SMSP_STAT_TRANSMIT_ENABLE_BIT];
					st_nxt.receive_enable_bit  = wb_dat_i[SMSP_STAT_RECEIVE_ENABLE_BIT];
				end
				SMSP_IDX_AUX: begin
					st_nxt.ss_out = wb_dat_i[SMSP_AUX_SSOUT];
					st_nxt.ss_dir = wb_dat_i[SMSP_AUX_SSDIR];
					st_nxt.irq_en = wb_dat_i[SMSP_AUX_IE];
				end
				default: st_nxt.ack = access;
			endcase
		end
		// Read mux, registered so the answer appears with the acknowledge.
		st_nxt.dat = 32'h0000_0000;
		if (access && !wb_we_i) begin
			case (idx)
				SMSP_IDX_CTRL: st_nxt.dat[7:0] = st_r.ctrl;
				SMSP_IDX_DATA: begin
					st_nxt.dat[7:0] = st_r.rx;
					data_acc        = 1'b1;
				end
				SMSP_IDX_STAT: begin
					st_nxt.dat[7:0] = {st_r.tc, st_r.wcol, st_r.ss_high, 1'b0,
						st_r.twopin, st_r.select_enable_bit, st_r.transmit_enable_bit, st_r.receive_enable_bit};
					st_nxt.rd_armed = st_r.tc || st_r.wcol;
				end
				SMSP_IDX_AUX: st_nxt.dat[7:0] = {5'h00, st_r.irq_en, st_r.ss_dir, st_r.ss_out};
				default: st_nxt.dat = 32'h0000_0000;
			endcase
		end

		// Flag clearing runs before any set below, so a coincident event wins.
		if (data_acc && st_r.rd_armed) begin
			st_nxt.rd_armed = 1'b0;
			if (!st_r.irq_en) begin
				st_nxt.tc   = 1'b0;
				st_nxt.wcol = 1'b0;
			end
		end
		if (int_ack && st_r.irq_en) begin
			st_nxt.tc = 1'b0;
		end
		// A collision in the same cycle as the clearing access stays visible.
		if (col_ev) begin
			st_nxt.wcol = 1'b1;
		end

		// Master clock divider; one event per half period of the serial clock.
		// Returning data crosses the synchroniser, so reception needs a half period of three clocks.
		// The two fastest rates therefore transmit correctly but cannot receive.
		if (st_r.fsm == SMSP_SHIFT && mst) begin
			if (st_r.div_cnt == half - 7'h01) begin
				st_nxt.div_cnt = 7'h00;
				st_nxt.sck     = !st_r.sck;
				edge_ev        = 1'b1;
				lead           = (st_r.sck == clock_idle_level_bit);
				trail          = (st_r.sck != clock_idle_level_bit);
			end else begin
				st_nxt.div_cnt = st_r.div_cnt + 7'h01;
			end
		end else if (st_r.fsm == SMSP_SHIFT && !ss_int && sck_s != st_r.sck_prev) begin
			edge_ev = 1'b1;
			lead    = (st_r.sck_prev == clock_idle_level_bit);
			trail   = (st_r.sck_prev != clock_idle_level_bit);
		end
		st_nxt.sck_prev = sck_s;

		// Phase picks which edge samples and which edge presents the next bit.
		sample = clock_edge_phase_bit ? trail : lead;
		setup  = clock_edge_phase_bit ? lead : trail;
		if (sample) begin
			st_nxt.sh      = sh_in;
			st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
		end
		if (setup) begin
			st_nxt.out_bit = lsbf ? st_r.sh[0] : st_r.sh[7];
		end
		if (edge_ev) begin
			st_nxt.edge_cnt = st_r.edge_cnt + 4'h1;
		end
		// A master finishes after the last edge, a slave after the eighth sample.
		if ((mst && edge_ev && st_r.edge_cnt == SMSP_LAST_EDGE) ||
			(!mst && sample && st_r.bit_cnt == SMSP_LAST_BIT)) begin
			st_nxt.fsm = SMSP_IDLE;
			st_nxt.rx  = st_nxt.sh;
			st_nxt.tc  = 1'b1;
		end

		// An idle slave select resets shifting but keeps the armed byte.
		if (!mst && ss_int) begin
			st_nxt.sh       = st_r.tx;
			st_nxt.out_bit  = lsbf ? st_r.tx[0] : st_r.tx[7];
			st_nxt.bit_cnt  = 3'h0;
			st_nxt.edge_cnt = 4'h0;
		end

		// Another master pulling select low demotes this one to avoid contention.
		if (en && mst && ss_input && !ss_s) begin
			st_nxt.ctrl[SMSP_CTRL_MS] = 1'b0;
			st_nxt.tc                 = 1'b1;
			st_nxt.fsm                = SMSP_IDLE;
			st_nxt.edge_cnt           = 4'h0;
			st_nxt.bit_cnt            = 3'h0;
		end

		// Rising select input, either role.
		if (ss_input && ss_s && !st_r.ss_prev) begin
			st_nxt.ss_high = 1'b1;
		end
		st_nxt.ss_prev = ss_s;

		// A disabled port stops at once and parks the clock at its idle level.
		if (!en) begin
			st_nxt.fsm      = SMSP_IDLE;
			st_nxt.sck      = clock_idle_level_bit;
			st_nxt.div_cnt  = 7'h00;
			st_nxt.edge_cnt = 4'h0;
			st_nxt.bit_cnt  = 3'h0;
		end

		// Pin drive from the updated state, so drives follow role changes promptly.
		st_nxt.irq          = st_nxt.tc && st_nxt.irq_en;
		st_nxt.pins.sck_oe  = en && st_nxt.ctrl[SMSP_CTRL_MS];
		st_nxt.pins.sck_o   = (st_nxt.fsm == SMSP_SHIFT) ? st_nxt.sck : st_nxt.ctrl[SMSP_CTRL_CLOCK_IDLE_LEVEL_BIT];
		st_nxt.pins.mosi_oe = en && st_nxt.ctrl[SMSP_CTRL_MS] && st_nxt.transmit_enable_bit;
		st_nxt.pins.mosi_o  = st_nxt.out_bit;
		st_nxt.pins.miso_oe = en && !st_nxt.ctrl[SMSP_CTRL_MS] && st_nxt.transmit_enable_bit && !ss_int;
		st_nxt.pins.miso_o  = st_nxt.out_bit;
		st_nxt.pins.ss_oe   = st_nxt.ctrl[SMSP_CTRL_MS] && st_nxt.select_enable_bit && st_nxt.ss_dir;
		st_nxt.pins.ss_o    = st_nxt.ss_out;
	end

	// Single state register; everything resets to zero.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_r <= SMSP_STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign irq      = st_r.irq;
	assign sck_o    = st_r.pins.sck_o;
	assign sck_oe   = st_r.pins.sck_oe;
	assign mosi_o   = st_r.pins.mosi_o;
	assign mosi_oe  = st_r.pins.mosi_oe;
	assign miso_o   = st_r.pins.miso_o;
	assign miso_oe  = st_r.pins.miso_oe;
	assign ss_n_o   = st_r.pins.ss_o;
	assign ss_n_oe  = st_r.pins.ss_oe;

endmodule : smsp_top
`default_nettype wire

// ==== verif/smsp_properties.sv ====
// Port-level assertions for the serial peripheral port.
`timescale 1ns/1ps
`default_nettype none
module smsp_properties (
	input wire logic        clk_sys,  // Clock.
	input wire logic        rst_n,    // Reset.
	input wire logic        wb_cyc_i, // Cycle.
	input wire logic        wb_stb_i, // Strobe.
	input wire logic        wb_we_i,  // Write.
	input wire logic [11:0] wb_adr_i, // Address.
	input wire logic [3:0]  wb_sel_i, // Selects.
	input wire logic [31:0] wb_dat_i, // Data.
	input wire logic        wb_ack_o, // Ack.
	input wire logic        int_ack,  // Serviced.
	input wire logic        irq,      // Request.
	input wire logic        sck_oe,   // Clock drive.
	input wire logic        mosi_oe,  // Out drive.
	input wire logic        miso_oe   // In drive.
);
	logic ms_r;
	logic tx_r;
	logic ie_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Shadows of written bits, taken at the edge that takes the write, as the port does.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ms_r <= 1'b0;
			tx_r <= 1'b0;
			ie_r <= 1'b0;
		end else if (!wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i[11:2] == 10'h0d2) ms_r <= wb_dat_i[5];
			if (wb_adr_i[11:2] == 10'h0d4) tx_r <= wb_dat_i[1];
			if (wb_adr_i[11:2] == 10'h0d5) ie_r <= wb_dat_i[2];
		end
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_ack_follows: assert property (s_req |=> s_ack_pulse)
		else $error("request not answered by one ack pulse");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
		else $error("ack without a request");
	a_reset_quiet: assert property ($rose(rst_n) |-> !wb_ack_o && !irq && !sck_oe)
		else $error("outputs active after reset");
	a_tx_release: assert property (!tx_r [*2] |-> !mosi_oe && !miso_oe)
		else $error("data pin driven with transmit off");
	a_irq_cause: assert property ($rose(irq) |-> ie_r)
		else $error("interrupt while disabled");
	a_irq_cleared: assert property (int_ack && ie_r |-> ##2 !irq)
		else $error("interrupt not cleared by service");
	a_roles_apart: assert property (sck_oe |-> !miso_oe)
		else $error("clock and in-data both driven");
	a_slave_no_clock: assert property (!ms_r [*2] |-> !sck_oe)
		else $error("clock driven in slave role");
endmodule : smsp_properties
bind smsp_top smsp_properties i_props (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .int_ack, .irq, .sck_oe, .mosi_oe, .miso_oe);
`default_nettype wire

// ==== verif/smsp_partner.sv ====
// External serial slave model facing the port in master role.
`timescale 1ns/1ps
`default_nettype none
module smsp_partner (
	input  wire logic       sck,  // Serial clock.
	input  wire logic       mosi, // Data in.
	input  wire logic       ss_n, // Select, active low.
	input  wire logic [2:0] mode, // Bit order, idle level, phase.
	input  wire logic [7:0] tx,   // Byte returned.
	output logic            miso, // Data out.
	output logic      [7:0] rx    // Byte received.
);
	int n;
	initial miso = 1'b0;
	// Presents the next bit; past the eighth it holds.
	task put();
		if (n < 8) miso = tx[mode[2] ? n : 7 - n];
		n++;
	endtask : put
	// Released line shows the inverse of its last bit, so no stale value reads as data.
	always @(ss_n) begin
		n = 0;
		if (ss_n) miso = ~miso;
		else if (!mode[0]) put();
	end
	// Sample on the leading edge for phase 0, on the trailing one for phase 1.
	always @(sck) begin
		if (!ss_n && (((sck != mode[1]) ^ mode[0]) == 1'b1)) begin
			rx = mode[2] ? {mosi, rx[7:1]} : {rx[6:0], mosi};
		end else if (!ss_n) begin
			put();
		end
	end
endmodule : smsp_partner
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking bench for the serial port in master and slave roles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
	$display("BAD %0t got %h exp %h", $time, a, e); end end
module testbench;
	import smsp_pkg::*;
	logic        clk_sys, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, int_ack = 1'b0;
	logic        tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1, clock_idle_level_bit = 1'b0, clock_edge_phase_bit = 1'b0;
	logic        lsbf = 1'b0, ack, irq, sck_o, sck_oe, mosi_o, mosi_oe;
	logic        miso_o, miso_oe, ss_o, ss_oe, p_miso;
	logic [11:0] adr = 12'h000;
	logic [31:0] dat = 32'h0, dat_o, seed = 32'he79e087f;
	logic [7:0]  rv, ptx = 8'h00, prx, b, m, got;
	logic [2:0]  rt;
	logic [9:0]  rix[5] = '{SMSP_IDX_CTRL, SMSP_IDX_DATA, SMSP_IDX_STAT, SMSP_IDX_AUX, 10'h0f0};
	logic [7:0]  q[$];
	int          errors = 0, checked = 0, cyc_cnt = 0, n, k;
	wire logic   sck_w = sck_oe ? sck_o : tb_sck;
	wire logic   mosi_w = mosi_oe ? mosi_o : tb_mosi;
	wire logic   miso_w = miso_oe ? miso_o : p_miso;
	wire logic   ss_w = ss_oe ? ss_o : tb_ss;
	smsp_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .int_ack(int_ack), .irq(irq), .sck_i(sck_w), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_o),
		.ss_n_oe(ss_oe));
	smsp_partner i_far (.sck(sck_w), .mosi(mosi_w), .ss_n(ss_w), .mode({lsbf, clock_idle_level_bit, clock_edge_phase_bit}),
		.tx(ptx), .miso(p_miso), .rx(prx));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task give_verdict();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// Classic single bus cycle; the request holds until ack is seen.
	task wb(input logic w, input logic [9:0] ix, input logic [7:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {ix, 2'h0};
		dat <= {24'h0, d};
		do @(posedge clk_sys); while (ack !== 1'b1);
		rv = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// Polls status until the done flag shows; the last read arms the flag clear.
	task wait_done();
		for (k = 0; k < 3000; k++) begin
			wb(1'b0, SMSP_IDX_STAT, 8'h00);
			if (rv[7] === 1'b1) break;
		end
	endtask : wait_done
	// One master exchange with the far slave; the select is driven low only after configuring.
	task mxfer(input logic [2:0] rate, input logic [7:0] tx);
		ptx = 8'(rnd());
		q.push_back(ptx);
		tb_sck <= clock_idle_level_bit;
		wb(1'b1, SMSP_IDX_AUX, 8'h03);
		wb(1'b1, SMSP_IDX_STAT, 8'h07);
		wb(1'b1, SMSP_IDX_CTRL, {1'b1, lsbf, 1'b1, clock_idle_level_bit, clock_edge_phase_bit, rate});
		wb(1'b1, SMSP_IDX_AUX, 8'h02);
		`CHK(ss_w, 1'b0)
		wb(1'b1, SMSP_IDX_DATA, tx);
		wait_done();
		wb(1'b0, SMSP_IDX_DATA, 8'h00);
		b = q.pop_front();
		`CHK(rv, b)
		`CHK(prx, tx)
		`CHK(sck_o, clock_idle_level_bit)
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7], 1'b0)
		wb(1'b1, SMSP_IDX_AUX, 8'h03);
	endtask : mxfer
	// External master in the port's place: link clock of 320 ns, mode 0, first bits first.
	task sbits(input int nb);
		tb_ss <= 1'b0;
		for (k = 0; k < nb; k++) begin
			tb_mosi <= m[7-k];
			repeat (4) @(posedge clk_sys);
			tb_sck <= 1'b1;
			repeat (4) @(posedge clk_sys);
			got = {got[6:0], miso_w};
			tb_sck <= 1'b0;
		end
		repeat (4) @(posedge clk_sys);
	endtask : sbits
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// A hang ends the run through the same verdict.
	always @(posedge clk_sys) begin
		cyc_cnt++;
		if (cyc_cnt == 80000) begin
			errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		foreach (rix[j]) begin
			wb(1'b0, rix[j], 8'h00);
			`CHK(rv, 8'h00)
		end
		// Rates below a three-clock half period cannot receive through the synchroniser.
		for (n = 0; n < 8; n++) begin
			{clock_idle_level_bit, clock_edge_phase_bit} = n[1:0];
			lsbf = 1'(rnd());
			rt = 3'(rnd());
			rt[0] = rt[0] | (rt[1:0] == 2'h0);
			mxfer(rt, 8'(rnd()));
		end
		// Second data write lands mid-transfer and must collide.
		wb(1'b1, SMSP_IDX_AUX, 8'h06);
		wb(1'b1, SMSP_IDX_DATA, 8'h5a);
		wb(1'b1, SMSP_IDX_DATA, 8'ha5);
		for (k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge clk_sys);
		`CHK(irq, 1'b1)
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7:6], 2'h3)
		int_ack <= 1'b1;
		@(posedge clk_sys);
		int_ack <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK(irq, 1'b0)
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7], 1'b0)
		// Interrupt off and select parked high, then a data read clears the collision flag.
		wb(1'b1, SMSP_IDX_AUX, 8'h03);
		wb(1'b0, SMSP_IDX_DATA, 8'h00);
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7:6], 2'h0)
		// Select as input in master role, then pulled low by another master.
		wb(1'b1, SMSP_IDX_AUX, 8'h00);
		wb(1'b1, SMSP_IDX_CTRL, 8'ha0);
		tb_ss <= 1'b0;
		repeat (8) @(posedge clk_sys);
		wb(1'b0, SMSP_IDX_CTRL, 8'h00);
		`CHK(rv, 8'h80)
		tb_ss <= 1'b1;
		repeat (8) @(posedge clk_sys);
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7:5], 3'h5)
		wb(1'b1, SMSP_IDX_STAT, 8'h07);
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[5], 1'b0)
		wb(1'b0, SMSP_IDX_DATA, 8'h00);
		// Slave role: a dropped select mid-byte discards it, then a whole byte follows.
		{clock_idle_level_bit, clock_edge_phase_bit, lsbf} = 3'h0;
		tb_sck <= 1'b0;
		b = 8'(rnd());
		m = 8'(rnd());
		wb(1'b1, SMSP_IDX_CTRL, 8'h80);
		wb(1'b1, SMSP_IDX_DATA, b);
		sbits(3);
		tb_ss <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sbits(8);
		`CHK(got, b)
		tb_ss <= 1'b1;
		wb(1'b0, SMSP_IDX_STAT, 8'h00);
		`CHK(rv[7], 1'b1)
		wb(1'b0, SMSP_IDX_DATA, 8'h00);
		`CHK(rv, m)
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
